/* File: ptm_timer_pair.sv */
/*
 * Paired 16-bit timers, usable as two independent timers/synchronous
 * counters or combined as one 32-bit timer/synchronous counter.
 * Assumes software access strobes are single-cycle and on ref_clk_i;
 * external clock/gate pins are asynchronous and are synchronised here.
 */
// Functional notes
// - In 32-bit mode first timer is low word, second timer high word.
// - In 32-bit mode the second control register is ignored entirely.
// - 32-bit uses first timer pins but raises second timer's flag.
// - 16-bit: each timer independent, timer or sync counter, no async mode.
// - First timer synchronises prescaler output; second timer does not.
// - 32-bit timer counts each cycle to combined period, wraps to zero.
// - Reading low count latches high count into holding register.
// - Write holding then low count; in 32-bit mode low write moves holding into high count.
// - 32-bit counter counts synchronised external rising edges, wraps at period.
// - In Idle, stop-in-idle bit set halts counting; clear keeps counting.
// - Gate enable: count instruction clock only while gate input is high.
// - 32-bit gating uses first timer; second gate bit ignored.
// - Gate falling edge ends accumulation, count kept until software clears.
// - 32-bit period match emits a converter trigger event.
// - Prescaler divides input clock by 1, 8, 64 or 256.
// - 32-bit mode uses only the first timer's prescaler.
// - Prescaler cleared on count write, timer-on clear, and reset.
// - Disabled timer's prescaler clock halts; then only the second's is still reset by a count write.
// - Control writes never clear the count registers.
// - During Sleep the timers do not advance.
// - Match or gate fall sets second flag; only software clears it.
// - Second timer interrupt requested only while its enable is set.
`timescale 1ns/10ps
module ptm_timer_pair
  import ptm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Power state
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  // Control words
  input wire logic [15:0] first_timer_control_i,
  input wire logic [15:0] second_timer_control_i,
  input wire logic [15:0] low_period_reg_i,
  input wire logic [15:0] high_period_reg_i,
  // Software count access
  input wire ptm_pkg::ptm_cnt_acc_t low_acc_i,
  input wire ptm_pkg::ptm_cnt_acc_t high_acc_i,
  input wire logic hold_wr_i,
  input wire logic [15:0] hold_wdata_i,
  // Flag clears and enables
  input wire logic first_irq_flag_clr_i,
  input wire logic second_timer_irq_flag_clr_i,
  input wire logic first_irq_enable_i,
  input wire logic second_timer_irq_enable_i,
  // Pins
  input wire logic first_timer_ext_clock_pin_i,
  input wire logic second_ext_clock_pin_i,
  // Status
  output logic [15:0] low_count_reg_o,
  output logic [15:0] high_count_reg_o,
  output logic [15:0] high_word_holding_reg_o,
  output logic first_irq_flag_o,
  output logic second_timer_irq_flag_o,
  output logic first_irq_o,
  output logic second_timer_irq_o,
  output logic adc_trigger_o
);
  ptm_ctl_t c1, c2;
  logic pin1_s, pin2_s, pin1_q, pin2_q, pin1_d, pin2_d;
  logic in1, in2, ps1_tick, ps2_tick, ps1_clr, ps2_clr;
  logic inc1, inc2, sync1_q, sync1_d, mode32, halt, fall1, fall2;
  logic on1_q, on2_q, on1_d, on2_d;
  logic [15:0] lo_q, lo_d, hi_q, hi_d, hold_q, hold_d;
  logic f1_q, f1_d, f2_q, f2_d, irq1_q, irq1_d, irq2_q, irq2_d, adc_q, adc_d;
  logic match32, match_lo, match_hi;

  ptm_sync2 u_sync1 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(first_timer_ext_clock_pin_i),
    .sync_o(pin1_s)
  );

  ptm_sync2 u_sync2 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(second_ext_clock_pin_i),
    .sync_o(pin2_s)
  );

  always_comb begin
    c1 = ptm_decode(first_timer_control_i);
    c2 = ptm_decode(second_timer_control_i);
    mode32 = c1.t32;
    halt = cpu_sleep_i;
    pin1_d = pin1_s;
    pin2_d = pin2_s;
    on1_d = c1.on;
    on2_d = c2.on;
    fall1 = pin1_q & ~pin1_s;
    fall2 = pin2_q & ~pin2_s;
    // Input ticks: external rising edge, gated cycle, or every cycle
    if (c1.cs) begin
      in1 = pin1_s & ~pin1_q;
    end else if (c1.gate) begin
      in1 = pin1_s;
    end else begin
      in1 = 1'b1;
    end
    if (c2.cs) begin
      in2 = pin2_s & ~pin2_q;
    end else if (c2.gate) begin
      in2 = pin2_s;
    end else begin
      in2 = 1'b1;
    end
    // Idle stop and timer-on gate the prescaler clock
    in1 = in1 & c1.on & ~halt & ~(cpu_idle_i & c1.sidl);
    in2 = in2 & c2.on & ~halt & ~(cpu_idle_i & c2.sidl) & ~mode32;
    // Clear on count write or on-bit falling; halted timer's cannot clear
    // Count writes reach the first prescaler only while its timer is on and not in Sleep
    ps1_clr = (((low_acc_i.wr | (mode32 & high_acc_i.wr)) & c1.on) | (on1_q & ~c1.on))
      & ~halt;
    ps2_clr = (high_acc_i.wr | (on2_q & ~c2.on)) & ~halt;
  end

  ptm_prescaler u_ps1 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(ps1_clr),
    .ps_i(c1.ps),
    .tick_i(in1),
    .tick_o(ps1_tick)
  );

  ptm_prescaler u_ps2 (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .clr_i(ps2_clr),
    .ps_i(c2.ps),
    .tick_i(in2),
    .tick_o(ps2_tick)
  );

  always_comb begin
    // First timer retimes its prescaler output; costs one cycle of lag
    sync1_d = ps1_tick;
    inc1 = sync1_q;
    inc2 = ps2_tick;
    match32 = ({hi_q, lo_q} == {high_period_reg_i, low_period_reg_i});
    match_lo = (lo_q == low_period_reg_i);
    match_hi = (hi_q == high_period_reg_i);
    lo_d = lo_q;
    hi_d = hi_q;
    hold_d = hold_q;
    // Clear first; any set below overrides it, so a same-cycle event wins
    f1_d = f1_q & ~first_irq_flag_clr_i;
    f2_d = f2_q & ~second_timer_irq_flag_clr_i;
    adc_d = 1'b0;
    if (low_acc_i.rd) begin
      hold_d = hi_q;
    end
    if (hold_wr_i) begin
      hold_d = hold_wdata_i;
    end
    if (mode32) begin
      if (inc1) begin
        if (match32) begin
          lo_d = 16'h0000;
          hi_d = 16'h0000;
          f2_d = 1'b1;
          adc_d = 1'b1;
        end else begin
          {hi_d, lo_d} = {hi_q, lo_q} + 32'h0000_0001;
        end
      end
      if (c1.on & c1.gate & ~c1.cs & fall1 & ~halt) begin
        f2_d = 1'b1;
      end
    end else begin
      if (inc1) begin
        if (match_lo) begin
          lo_d = 16'h0000;
          f1_d = 1'b1;
        end else begin
          lo_d = lo_q + 16'h0001;
        end
      end
      if (inc2) begin
        if (match_hi) begin
          hi_d = 16'h0000;
          f2_d = 1'b1;
        end else begin
          hi_d = hi_q + 16'h0001;
        end
      end
      if (c1.on & c1.gate & ~c1.cs & fall1 & ~halt) begin
        f1_d = 1'b1;
      end
      if (c2.on & c2.gate & ~c2.cs & fall2 & ~halt) begin
        f2_d = 1'b1;
      end
    end
    // Software writes override counting; control writes never load the count registers
    if (low_acc_i.wr) begin
      lo_d = low_acc_i.wdata;
      if (mode32) begin
        hi_d = hold_q;
      end
    end
    if (high_acc_i.wr) begin
      hi_d = high_acc_i.wdata;
    end
    irq1_d = f1_d & first_irq_enable_i;
    irq2_d = f2_d & second_timer_irq_enable_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin1_q <= 1'b0;
      pin2_q <= 1'b0;
      on1_q <= 1'b0;
      on2_q <= 1'b0;
      sync1_q <= 1'b0;
      lo_q <= COUNT_RESET;
      hi_q <= COUNT_RESET;
      hold_q <= COUNT_RESET;
      f1_q <= 1'b0;
      f2_q <= 1'b0;
      irq1_q <= 1'b0;
      irq2_q <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      pin1_q <= pin1_d;
      pin2_q <= pin2_d;
      on1_q <= on1_d;
      on2_q <= on2_d;
      sync1_q <= sync1_d;
      lo_q <= lo_d;
      hi_q <= hi_d;
      hold_q <= hold_d;
      f1_q <= f1_d;
      f2_q <= f2_d;
      irq1_q <= irq1_d;
      irq2_q <= irq2_d;
      adc_q <= adc_d;
    end
  end

  assign low_count_reg_o = lo_q;
  assign high_count_reg_o = hi_q;
  assign high_word_holding_reg_o = hold_q;
  assign first_irq_flag_o = f1_q;
  assign second_timer_irq_flag_o = f2_q;
  assign first_irq_o = irq1_q;
  assign second_timer_irq_o = irq2_q;
  assign adc_trigger_o = adc_q;
endmodule

/* File: ptm_pkg.sv */
/*
 * Package for the paired 16/32-bit timer: control word layout, prescale
 * encodings and reset values shared by the timer files.
 * Assumes a single 40 MHz clock domain; no bus, all controls are ports.
 */
package ptm_pkg;

  localparam int unsigned REF_CLK_MHZ = 40;

  // Control word bit positions
  localparam int unsigned CTL_ON_BIT = 15;
  localparam int unsigned CTL_SIDL_BIT = 13;
  localparam int unsigned CTL_GATE_BIT = 6;
  localparam int unsigned CTL_PS_HI_BIT = 5;
  localparam int unsigned CTL_PS_LO_BIT = 4;
  localparam int unsigned CTL_T32_BIT = 3;
  localparam int unsigned CTL_CS_BIT = 1;

  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // Prescale field encodings
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV8 = 2'h1;
  localparam logic [1:0] PS_DIV64 = 2'h2;
  localparam logic [1:0] PS_DIV256 = 2'h3;
  localparam logic [7:0] PS_TC8 = 8'h07;
  localparam logic [7:0] PS_TC64 = 8'h3F;
  localparam logic [7:0] PS_TC256 = 8'hFF;

  // Software access strobes to one timer's count word
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } ptm_cnt_acc_t;

  // Decoded control word
  typedef struct packed {
    logic       on;
    logic       sidl;
    logic       gate;
    logic [1:0] ps;
    logic       t32;
    logic       cs;
  } ptm_ctl_t;

  function automatic ptm_ctl_t ptm_decode(input logic [15:0] w);
    ptm_ctl_t c;
    c.on = w[CTL_ON_BIT];
    c.sidl = w[CTL_SIDL_BIT];
    c.gate = w[CTL_GATE_BIT];
    c.ps = w[CTL_PS_HI_BIT:CTL_PS_LO_BIT];
    c.t32 = w[CTL_T32_BIT];
    c.cs = w[CTL_CS_BIT];
    return c;
  endfunction

endpackage

/* File: ptm_sync2.sv */
/*
 * Two-flop synchroniser for a pin level.
 * Assumes the pin is asynchronous to ref_clk_i.
 */
`timescale 1ns/10ps
module ptm_sync2 (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Level
  input wire logic async_i,
  output logic sync_o
);
  logic meta_q, meta_d, sync_q, sync_d;

  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;
endmodule

/* File: ptm_prescaler.sv */
/*
 * Prescaler for one timer: emits a one-cycle tick every 1, 8, 64 or 256
 * input ticks. Clear input restarts the division.
 * Assumes inputs come from logic on ref_clk_i.
 */
`timescale 1ns/10ps
module ptm_prescaler
  import ptm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic [1:0] ps_i,
  input wire logic tick_i,
  // Output
  output logic tick_o
);
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] tc;

  always_comb begin
    unique case (ps_i)
      PS_DIV1: tc = 8'h00;
      PS_DIV8: tc = PS_TC8;
      PS_DIV64: tc = PS_TC64;
      default: tc = PS_TC256;
    endcase
    cnt_d = cnt_q;
    tick_o = 1'b0;
    if (clr_i) begin
      cnt_d = 8'h00;
    end else if (tick_i) begin
      if (cnt_q >= tc) begin
        cnt_d = 8'h00;
        tick_o = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

/* File: ptm_pin_src.sv */
/* Pin source for the timer pair's clock or gate pins.
   Assumes the bench calls its tasks; edges are unrelated to ref_clk_i. */
`timescale 1ns/10ps
module ptm_pin_src (
  // Pin
  output logic pin_o
);
  initial pin_o = 1'b0;
  // Edges wider than two clocks so the synchroniser sees each one
  task automatic pulses(input int n);
    repeat (n) begin
      #60 pin_o = 1'b1;
      #60 pin_o = 1'b0;
    end
  endtask
  task automatic gate_for(input int ns);
    pin_o = 1'b1;
    #(ns) pin_o = 1'b0;
  endtask
endmodule

/* File: ptm_timer_pair_properties.sv */
/* Port assertions for the timer pair.
   Assumes one clock and a synchronous active-high reset; bound below. */
`timescale 1ns/10ps
module ptm_pair_props
  import ptm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Inputs
  input wire logic cpu_idle_i,
  input wire logic cpu_sleep_i,
  input wire logic [15:0] first_timer_control_i,
  input wire ptm_pkg::ptm_cnt_acc_t low_acc_i,
  input wire ptm_pkg::ptm_cnt_acc_t high_acc_i,
  input wire logic hold_wr_i,
  input wire logic [15:0] hold_wdata_i,
  input wire logic second_timer_irq_flag_clr_i,
  input wire logic second_timer_irq_enable_i,
  // Outputs
  input wire logic [15:0] low_count_reg_o,
  input wire logic [15:0] high_count_reg_o,
  input wire logic [15:0] high_word_holding_reg_o,
  input wire logic second_timer_irq_flag_o,
  input wire logic second_timer_irq_o,
  input wire logic adc_trigger_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);
  // Idle only halts the pair when stop-in-idle is set
  wire halt = cpu_sleep_i |
    (cpu_idle_i & first_timer_control_i[13] & first_timer_control_i[3]);
  flag_hold_a: assert property (
    $past(!rst_i) && $past(second_timer_irq_flag_o) && !$past(second_timer_irq_flag_clr_i)
    |-> second_timer_irq_flag_o) else $error("flag dropped without clear");
  irq_gate_a: assert property (
    $past(!rst_i) |-> second_timer_irq_o ==
    (second_timer_irq_flag_o & $past(second_timer_irq_enable_i))) else $error("irq mismatch");
  adc_wrap_a: assert property (
    adc_trigger_o |-> low_count_reg_o == 16'h0000 && high_count_reg_o == 16'h0000
    && second_timer_irq_flag_o) else $error("trigger without wrap");
  adc_mode_a: assert property (
    adc_trigger_o |-> $past(first_timer_control_i[3])) else $error("trigger in 16-bit");
  halt_freeze_a: assert property (
    $past(halt) && $past(halt, 2) && $past(halt, 3) && !$past(rst_i)
    && !$past(low_acc_i.wr) && !$past(high_acc_i.wr)
    |-> $stable(low_count_reg_o) && $stable(high_count_reg_o)) else $error("count moved");
  low_write_a: assert property (
    low_acc_i.wr && !cpu_sleep_i |=> low_count_reg_o == $past(low_acc_i.wdata)
    && (!$past(first_timer_control_i[3])
    || high_count_reg_o == $past(high_word_holding_reg_o))) else $error("low write");
  hold_load_a: assert property (
    hold_wr_i && !low_acc_i.rd && !cpu_sleep_i
    |=> high_word_holding_reg_o == $past(hold_wdata_i)) else $error("holding write");
  read_latch_a: assert property (
    low_acc_i.rd && !hold_wr_i && !cpu_sleep_i
    |=> high_word_holding_reg_o == $past(high_count_reg_o)) else $error("read latch");
endmodule
bind ptm_timer_pair ptm_pair_props u_props (.*);

/* File: tb.sv */
/* Self-checking bench: coherent access, 32-bit wrap, prescale, idle/sleep,
   gating and 16-bit mode. Assumes the checker binds itself. */
`timescale 1ns/10ps
module tb;
  import ptm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic idle = 1'b0, slp = 1'b0, hw = 1'b0, clr1 = 1'b0, clr2 = 1'b0, en1 = 1'b0;
  logic en2 = 1'b0;
  logic [15:0] c1 = 16'h0000, c2 = 16'h0000, p1 = 16'hFFFF, p2 = 16'hFFFF, hdat = 16'h0000;
  ptm_cnt_acc_t la = '0, ha = '0;
  logic [15:0] lo, hi, hld;
  logic f1, f2, q1, q2, adc;
  wire pin1, pin2;
  int errors = 0, checks_done = 0, cycles = 0;
  ptm_pin_src src1 (.pin_o(pin1));
  ptm_pin_src src2 (.pin_o(pin2));
  ptm_timer_pair dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .cpu_idle_i(idle),
    .cpu_sleep_i(slp), .first_timer_control_i(c1), .second_timer_control_i(c2),
    .low_period_reg_i(p1), .high_period_reg_i(p2), .low_acc_i(la), .high_acc_i(ha),
    .hold_wr_i(hw), .hold_wdata_i(hdat), .first_irq_flag_clr_i(clr1),
    .second_timer_irq_flag_clr_i(clr2), .first_irq_enable_i(en1),
    .second_timer_irq_enable_i(en2), .first_timer_ext_clock_pin_i(pin1),
    .second_ext_clock_pin_i(pin2), .low_count_reg_o(lo), .high_count_reg_o(hi),
    .high_word_holding_reg_o(hld), .first_irq_flag_o(f1), .second_timer_irq_flag_o(f2),
    .first_irq_o(q1), .second_timer_irq_o(q2), .adc_trigger_o(adc));
  initial forever #12.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      final_report;
    end
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic w32(input logic [31:0] v);
    @(posedge ref_clk_i);
    hw <= 1'b1;
    hdat <= v[31:16];
    @(posedge ref_clk_i);
    hw <= 1'b0;
    la <= '{wr: 1'b1, rd: 1'b0, wdata: v[15:0]};
    @(posedge ref_clk_i);
    la <= '0;
  endtask
  task automatic wait_lo(input logic [15:0] v, output int n);
    n = 0;
    while (lo !== v && n < 600) begin
      @(negedge ref_clk_i);
      n++;
    end
  endtask
  task automatic t_coh;
    @(posedge ref_clk_i);
    c1 <= 16'h0008;
    w32(32'h1234ABCD);
    @(negedge ref_clk_i);
    chk(lo, 16'hABCD);
    chk(hi, 16'h1234);
    @(posedge ref_clk_i);
    ha <= '{wr: 1'b1, rd: 1'b0, wdata: 16'h5678};
    @(posedge ref_clk_i);
    ha <= '0;
    la.rd <= 1'b1;
    c1 <= 16'h2078;
    @(posedge ref_clk_i);
    la.rd <= 1'b0;
    @(negedge ref_clk_i);
    chk(hld, 16'h5678);
    chk(lo, 16'hABCD);
    $display("t_coh done");
  endtask
  task automatic t_wrap;
    int k;
    @(posedge ref_clk_i);
    c1 <= 16'h0008;
    c2 <= 16'h8032;
    p1 <= 16'h0001;
    p2 <= 16'h0001;
    en2 <= 1'b1;
    w32(32'h0000FFFE);
    @(posedge ref_clk_i);
    c1 <= 16'h8008;
    k = 0;
    while (adc !== 1'b1 && k < 20) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk(adc, 1'b1);
    chk(hi, 16'h0000);
    chk(f2, 1'b1);
    chk(q2, 1'b1);
    chk(f1, 1'b0);
    @(negedge ref_clk_i);
    chk(lo, 16'h0001);
    @(posedge ref_clk_i);
    c1 <= 16'h0008;
    clr2 <= 1'b1;
    en2 <= 1'b0;
    @(posedge ref_clk_i);
    clr2 <= 1'b0;
    @(negedge ref_clk_i);
    chk(f2, 1'b0);
    $display("t_wrap done");
  endtask
  task automatic t_ps;
    int r[4] = '{1, 8, 64, 256};
    int n;
    logic [15:0] v;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_i);
      c1 <= {8'h00, 2'b00, i[1:0], 4'h8};
      c2 <= 16'h0030;
      w32(32'h0);
      @(posedge ref_clk_i);
      c1[15] <= 1'b1;
      wait_lo(16'h0001, n);
      wait_lo(16'h0002, n);
      chk(16'(n), 16'(r[i]));
    end
    @(posedge ref_clk_i);
    c1 <= 16'hA008;
    idle <= 1'b1;
    repeat (3) @(negedge ref_clk_i);
    v = lo;
    repeat (4) @(negedge ref_clk_i);
    chk(lo, v);
    @(posedge ref_clk_i);
    idle <= 1'b0;
    slp <= 1'b1;
    repeat (3) @(negedge ref_clk_i);
    v = lo;
    repeat (4) @(negedge ref_clk_i);
    chk(lo, v);
    @(posedge ref_clk_i);
    slp <= 1'b0;
    $display("t_ps done");
  endtask
  task automatic t_gate;
    logic [15:0] v;
    @(posedge ref_clk_i);
    c1 <= 16'h0048;
    w32(32'h0);
    @(posedge ref_clk_i);
    c1 <= 16'h8048;
    repeat (6) @(negedge ref_clk_i);
    chk(lo, 16'h0000);
    src1.gate_for(200);
    repeat (5) @(negedge ref_clk_i);
    v = lo;
    chk(f2, 1'b1);
    chk(16'(v >= 16'h0007 && v <= 16'h0009), 16'h0001);
    repeat (4) @(negedge ref_clk_i);
    chk(lo, v);
    @(posedge ref_clk_i);
    c1 <= 16'h0008;
    clr2 <= 1'b1;
    @(posedge ref_clk_i);
    clr2 <= 1'b0;
    $display("t_gate done");
  endtask
  task automatic t_16;
    int k;
    @(posedge ref_clk_i);
    c1 <= 16'h0000;
    c2 <= 16'h0002;
    p1 <= 16'h0003;
    p2 <= 16'hFFFF;
    en1 <= 1'b1;
    la <= '{wr: 1'b1, rd: 1'b0, wdata: 16'h0000};
    ha <= '{wr: 1'b1, rd: 1'b0, wdata: 16'h0000};
    @(posedge ref_clk_i);
    la <= '0;
    ha <= '0;
    c1 <= 16'h8000;
    c2 <= 16'h8002;
    k = 0;
    while (f1 !== 1'b1 && k < 20) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk(lo, 16'h0000);
    chk(q1, 1'b1);
    chk(f2, 1'b0);
    src2.pulses(5);
    repeat (6) @(negedge ref_clk_i);
    chk(hi, 16'h0005);
    $display("t_16 done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_coh;
    t_wrap;
    t_ps;
    t_gate;
    t_16;
    final_report;
  end
endmodule
